// [hw/bwip_dev_port.sv]
// device end of the byte-wide interprocessor port, with its two word FIFOs
//
// Function
// - twelve link pins: four control, eight data
// - control logic arbitrates data-line ownership and timing
// - FIFOs reached by local write and read
// - request, then acknowledge, before data moves
// - word crosses as four successive bytes
// - four bytes reassembled into receive FIFO
// - eight-word transmit and receive FIFOs
// - link either direction, at most 24 Mbytes/s
`timescale 1ns/100ps
`default_nettype none
`include "bwip_regs.svh"

module bwip_dev_port #(
    parameter int DEPTH = `BWIP_FIFO_DEPTH,
    parameter int BYTE_CYC = `BWIP_BYTE_CYC,
    parameter bit HIGH_PRIO = 1'b1
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic tx_wr_i,
    input wire logic [`BWIP_WORD_W-1:0] tx_wdata_i,
    output logic tx_full_o,
    output logic tx_empty_o,
    input wire logic rx_rd_i,
    output logic [`BWIP_WORD_W-1:0] rx_rdata_o,
    output logic rx_full_o,
    output logic rx_empty_o,
    bwip_link_if.dev link
);
    localparam int AW = $clog2(DEPTH);
    localparam int SW = $clog2(BYTE_CYC + 1);
    localparam logic [1:0] LAST_BYTE = 2'(`BWIP_BYTES_PER_WORD - 1);
    localparam logic [SW-1:0] LAST_SUB = SW'(BYTE_CYC - 1);
    localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);

    // wrap-around pointer step, shared by both FIFOs
    function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
        logic [AW-1:0] r;
        r = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
        return r;
    endfunction

    // transmit FIFO
    logic [`BWIP_WORD_W-1:0] tx_mem_q [DEPTH];
    logic [AW-1:0] tx_wp_q;
    logic [AW-1:0] tx_wp_d;
    logic [AW-1:0] tx_rp_q;
    logic [AW-1:0] tx_rp_d;
    logic [AW:0] tx_cnt_q;
    logic [AW:0] tx_cnt_d;
    logic tx_push;
    logic tx_pop;

    // receive FIFO
    logic [`BWIP_WORD_W-1:0] rx_mem_q [DEPTH];
    logic [AW-1:0] rx_wp_q;
    logic [AW-1:0] rx_wp_d;
    logic [AW-1:0] rx_rp_q;
    logic [AW-1:0] rx_rp_d;
    logic [AW:0] rx_cnt_q;
    logic [AW:0] rx_cnt_d;
    logic rx_push;
    logic rx_pop;
    logic [`BWIP_WORD_W-1:0] rx_word;

    // link engine
    bwip_pkg::bwip_state_e st_q;
    bwip_pkg::bwip_state_e st_d;
    logic [1:0] byte_q;
    logic [1:0] byte_d;
    logic [SW-1:0] sub_q;
    logic [SW-1:0] sub_d;
    logic [`BWIP_WORD_W-1:0] sh_q;
    logic [`BWIP_WORD_W-1:0] sh_d;
    logic last_sub;

    assign tx_full_o = (tx_cnt_q == FULL_CNT);
    assign tx_empty_o = (tx_cnt_q == '0);
    assign rx_full_o = (rx_cnt_q == FULL_CNT);
    assign rx_empty_o = (rx_cnt_q == '0);
    assign rx_rdata_o = rx_mem_q[rx_rp_q];

    // writes to a full FIFO and reads of an empty one are dropped
    assign tx_push = tx_wr_i && !tx_full_o;
    assign rx_pop = rx_rd_i && !rx_empty_o;

    // link pins
    assign link.dev_req = (st_q == bwip_pkg::BWIP_REQ) || (st_q == bwip_pkg::BWIP_SEND);
    assign link.dev_ack = (st_q == bwip_pkg::BWIP_GRANT) || (st_q == bwip_pkg::BWIP_RECV);
    assign link.dev_oe = (st_q == bwip_pkg::BWIP_SEND);
    assign link.dev_dout = sh_q[`BWIP_BYTE_W-1:0];

    always_comb begin
        tx_wp_d = tx_wp_q;
        tx_rp_d = tx_rp_q;
        tx_cnt_d = tx_cnt_q;
        if (tx_push) begin
            tx_wp_d = ptr_inc(tx_wp_q);
        end
        if (tx_pop) begin
            tx_rp_d = ptr_inc(tx_rp_q);
        end
        if (tx_push && !tx_pop) begin
            tx_cnt_d = tx_cnt_q + (AW + 1)'(1);
        end else if (tx_pop && !tx_push) begin
            tx_cnt_d = tx_cnt_q - (AW + 1)'(1);
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_wp_q <= '0;
            tx_rp_q <= '0;
            tx_cnt_q <= '0;
        end else begin
            tx_wp_q <= tx_wp_d;
            tx_rp_q <= tx_rp_d;
            tx_cnt_q <= tx_cnt_d;
        end
    end

    // storage carries no reset; occupancy is what marks it valid
    always_ff @(posedge clk_i) begin
        if (tx_push) begin
            tx_mem_q[tx_wp_q] <= tx_wdata_i;
        end
    end

    always_comb begin
        rx_wp_d = rx_wp_q;
        rx_rp_d = rx_rp_q;
        rx_cnt_d = rx_cnt_q;
        if (rx_push) begin
            rx_wp_d = ptr_inc(rx_wp_q);
        end
        if (rx_pop) begin
            rx_rp_d = ptr_inc(rx_rp_q);
        end
        if (rx_push && !rx_pop) begin
            rx_cnt_d = rx_cnt_q + (AW + 1)'(1);
        end else if (rx_pop && !rx_push) begin
            rx_cnt_d = rx_cnt_q - (AW + 1)'(1);
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_wp_q <= '0;
            rx_rp_q <= '0;
            rx_cnt_q <= '0;
        end else begin
            rx_wp_q <= rx_wp_d;
            rx_rp_q <= rx_rp_d;
            rx_cnt_q <= rx_cnt_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rx_push) begin
            rx_mem_q[rx_wp_q] <= rx_word;
        end
    end

    // one word is in flight at most, so granting while not full
    // guarantees room when the fourth byte lands
    always_comb begin
        st_d = st_q;
        byte_d = byte_q;
        sub_d = sub_q;
        sh_d = sh_q;
        tx_pop = 1'b0;
        rx_push = 1'b0;
        last_sub = (sub_q == LAST_SUB);
        rx_word = {link.dat, sh_q[`BWIP_WORD_W-1:`BWIP_BYTE_W]};
        case (st_q)
            bwip_pkg::BWIP_IDLE: begin
                // answering the peer comes before starting our own request
                if (link.peer_req && !rx_full_o) begin
                    st_d = bwip_pkg::BWIP_GRANT;
                end else if (!tx_empty_o) begin
                    st_d = bwip_pkg::BWIP_REQ;
                end
            end
            bwip_pkg::BWIP_REQ: begin
                if (link.peer_ack) begin
                    st_d = bwip_pkg::BWIP_SEND;
                    sh_d = tx_mem_q[tx_rp_q];
                    tx_pop = 1'b1;
                    byte_d = '0;
                    sub_d = '0;
                end else if (!HIGH_PRIO && link.peer_req && !rx_full_o) begin
                    // low priority end backs off so two requests cannot deadlock
                    st_d = bwip_pkg::BWIP_GRANT;
                end
            end
            bwip_pkg::BWIP_GRANT: begin
                st_d = bwip_pkg::BWIP_RECV;
                byte_d = '0;
                sub_d = '0;
            end
            bwip_pkg::BWIP_SEND: begin
                if (last_sub) begin
                    // byte slots are paced so the link never beats the peak rate
                    sub_d = '0;
                    sh_d = {8'h00, sh_q[`BWIP_WORD_W-1:`BWIP_BYTE_W]};
                    byte_d = byte_q + 2'h1;
                    if (byte_q == LAST_BYTE) begin
                        st_d = bwip_pkg::BWIP_IDLE;
                    end
                end else begin
                    sub_d = sub_q + SW'(1);
                end
            end
            bwip_pkg::BWIP_RECV: begin
                if (last_sub) begin
                    // sample at the end of the slot, when the byte has settled
                    sub_d = '0;
                    sh_d = rx_word;
                    byte_d = byte_q + 2'h1;
                    if (byte_q == LAST_BYTE) begin
                        rx_push = 1'b1;
                        st_d = bwip_pkg::BWIP_IDLE;
                    end
                end else begin
                    sub_d = sub_q + SW'(1);
                end
            end
            default: begin
                st_d = bwip_pkg::BWIP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= bwip_pkg::BWIP_IDLE;
            byte_q <= '0;
            sub_q <= '0;
            sh_q <= '0;
        end else begin
            st_q <= st_d;
            byte_q <= byte_d;
            sub_q <= sub_d;
            sh_q <= sh_d;
        end
    end

endmodule

`default_nettype wire

// [hw/bwip_link_if.sv]
// the twelve-line link: four handshake lines and a shared byte-wide data path
`timescale 1ns/100ps
`default_nettype none

interface bwip_link_if;
    logic dev_req;
    logic dev_ack;
    logic peer_req;
    logic peer_ack;
    bwip_pkg::bwip_byte_t dev_dout;
    logic dev_oe;
    bwip_pkg::bwip_byte_t peer_dout;
    logic peer_oe;
    bwip_pkg::bwip_byte_t dat;

    // level of the shared data lines; an undriven bus reads as zero
    assign dat = dev_oe ? dev_dout : (peer_oe ? peer_dout : 8'h00);

    modport dev (
        output dev_req,
        output dev_ack,
        output dev_dout,
        output dev_oe,
        input peer_req,
        input peer_ack,
        input dat
    );

    modport peer (
        output peer_req,
        output peer_ack,
        output peer_dout,
        output peer_oe,
        input dev_req,
        input dev_ack,
        input dat
    );
endinterface

`default_nettype wire

// [hw/bwip_peer_port.sv]
// far end of the byte-wide interprocessor port, one word each way held
`timescale 1ns/100ps
`default_nettype none
`include "bwip_regs.svh"

module bwip_peer_port #(
    parameter int BYTE_CYC = `BWIP_BYTE_CYC,
    parameter bit HIGH_PRIO = 1'b0
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic tx_valid_i,
    input wire logic [`BWIP_WORD_W-1:0] tx_data_i,
    output logic tx_ready_o,
    output logic rx_valid_o,
    output logic [`BWIP_WORD_W-1:0] rx_data_o,
    bwip_link_if.peer link
);
    localparam int SW = $clog2(BYTE_CYC + 1);
    localparam logic [1:0] LAST_BYTE = 2'(`BWIP_BYTES_PER_WORD - 1);
    localparam logic [SW-1:0] LAST_SUB = SW'(BYTE_CYC - 1);

    bwip_pkg::bwip_state_e st_q;
    bwip_pkg::bwip_state_e st_d;
    logic [1:0] byte_q;
    logic [1:0] byte_d;
    logic [SW-1:0] sub_q;
    logic [SW-1:0] sub_d;
    logic [`BWIP_WORD_W-1:0] sh_q;
    logic [`BWIP_WORD_W-1:0] sh_d;
    logic [`BWIP_WORD_W-1:0] hold_q;
    logic [`BWIP_WORD_W-1:0] hold_d;
    logic full_q;
    logic full_d;
    logic rxv_q;
    logic rxv_d;
    logic [`BWIP_WORD_W-1:0] rxd_q;
    logic [`BWIP_WORD_W-1:0] rxd_d;
    logic last_sub;
    logic [`BWIP_WORD_W-1:0] rx_word;

    assign tx_ready_o = !full_q;
    assign rx_valid_o = rxv_q;
    assign rx_data_o = rxd_q;
    assign link.peer_req = (st_q == bwip_pkg::BWIP_REQ) || (st_q == bwip_pkg::BWIP_SEND);
    assign link.peer_ack = (st_q == bwip_pkg::BWIP_GRANT) || (st_q == bwip_pkg::BWIP_RECV);
    assign link.peer_oe = (st_q == bwip_pkg::BWIP_SEND);
    assign link.peer_dout = sh_q[`BWIP_BYTE_W-1:0];

    // this end always has room: a received word is presented for one cycle
    always_comb begin
        st_d = st_q;
        byte_d = byte_q;
        sub_d = sub_q;
        sh_d = sh_q;
        hold_d = hold_q;
        full_d = full_q;
        rxv_d = 1'b0;
        rxd_d = rxd_q;
        last_sub = (sub_q == LAST_SUB);
        rx_word = {link.dat, sh_q[`BWIP_WORD_W-1:`BWIP_BYTE_W]};
        if (tx_valid_i && !full_q) begin
            hold_d = tx_data_i;
            full_d = 1'b1;
        end
        case (st_q)
            bwip_pkg::BWIP_IDLE: begin
                if (link.dev_req) begin
                    st_d = bwip_pkg::BWIP_GRANT;
                end else if (full_q) begin
                    st_d = bwip_pkg::BWIP_REQ;
                end
            end
            bwip_pkg::BWIP_REQ: begin
                if (link.dev_ack) begin
                    st_d = bwip_pkg::BWIP_SEND;
                    sh_d = hold_q;
                    full_d = 1'b0;
                    byte_d = '0;
                    sub_d = '0;
                end else if (!HIGH_PRIO && link.dev_req) begin
                    st_d = bwip_pkg::BWIP_GRANT;
                end
            end
            bwip_pkg::BWIP_GRANT: begin
                st_d = bwip_pkg::BWIP_RECV;
                byte_d = '0;
                sub_d = '0;
            end
            bwip_pkg::BWIP_SEND: begin
                if (last_sub) begin
                    sub_d = '0;
                    sh_d = {8'h00, sh_q[`BWIP_WORD_W-1:`BWIP_BYTE_W]};
                    byte_d = byte_q + 2'h1;
                    if (byte_q == LAST_BYTE) begin
                        st_d = bwip_pkg::BWIP_IDLE;
                    end
                end else begin
                    sub_d = sub_q + SW'(1);
                end
            end
            bwip_pkg::BWIP_RECV: begin
                if (last_sub) begin
                    sub_d = '0;
                    sh_d = rx_word;
                    byte_d = byte_q + 2'h1;
                    if (byte_q == LAST_BYTE) begin
                        rxv_d = 1'b1;
                        rxd_d = rx_word;
                        st_d = bwip_pkg::BWIP_IDLE;
                    end
                end else begin
                    sub_d = sub_q + SW'(1);
                end
            end
            default: begin
                st_d = bwip_pkg::BWIP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= bwip_pkg::BWIP_IDLE;
            byte_q <= '0;
            sub_q <= '0;
            sh_q <= '0;
            hold_q <= '0;
            full_q <= 1'b0;
            rxv_q <= 1'b0;
            rxd_q <= '0;
        end else begin
            st_q <= st_d;
            byte_q <= byte_d;
            sub_q <= sub_d;
            sh_q <= sh_d;
            hold_q <= hold_d;
            full_q <= full_d;
            rxv_q <= rxv_d;
            rxd_q <= rxd_d;
        end
    end

endmodule

`default_nettype wire

// [hw/bwip_pkg.sv]
// types shared by both ends of the byte-wide interprocessor port
`default_nettype none

package bwip_pkg;

    typedef enum logic [2:0] {
        BWIP_IDLE,
        BWIP_REQ,
        BWIP_GRANT,
        BWIP_SEND,
        BWIP_RECV
    } bwip_state_e;

    typedef logic [7:0] bwip_byte_t;

endpackage

`default_nettype wire

// [hw/bwip_regs.svh]
// timing, width and depth constants of the byte-wide interprocessor port
`ifndef BWIP_REGS_SVH
`define BWIP_REGS_SVH

`define BWIP_WORD_W 32
`define BWIP_BYTE_W 8
`define BWIP_BYTES_PER_WORD 4
`define BWIP_FIFO_DEPTH 8
`define BWIP_CLK_MHZ 200
// peak link rate per port, in Mbytes/s
`define BWIP_RATE_MBYTES 24
// least cycles per byte slot, rounded up: 200/24 -> 9
`define BWIP_BYTE_CYC ((`BWIP_CLK_MHZ + `BWIP_RATE_MBYTES - 1) / `BWIP_RATE_MBYTES)

`endif

// [testbench/bwip_link_checker.sv]
// link checker: handshake order, drive time and device byte pacing on the twelve lines
`timescale 1ns/100ps
`default_nettype none

module bwip_link_checker #(
    parameter int BYTE_CYC = 9
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic dev_req,
    input wire logic dev_ack,
    input wire logic peer_req,
    input wire logic peer_ack,
    input wire logic dev_oe,
    input wire logic peer_oe,
    input wire bwip_pkg::bwip_byte_t dat
);
    localparam int OE_LEN = 4 * BYTE_CYC;

    logic [7:0] dev_cnt_q;
    logic [7:0] dev_cnt_d;
    logic [7:0] peer_cnt_q;
    logic [7:0] peer_cnt_d;

    // cycles each end has driven the data lines in the current word
    always_comb begin
        dev_cnt_d = dev_oe ? dev_cnt_q + 8'h01 : 8'h00;
        peer_cnt_d = peer_oe ? peer_cnt_q + 8'h01 : 8'h00;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dev_cnt_q <= 8'h00;
            peer_cnt_q <= 8'h00;
        end else begin
            dev_cnt_q <= dev_cnt_d;
            peer_cnt_q <= peer_cnt_d;
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_dev_granted;
        dev_req && peer_ack && !dev_oe;
    endsequence
    sequence s_peer_granted;
        peer_req && dev_ack && !peer_oe;
    endsequence

    property p_one_driver;
        !(dev_oe && peer_oe);
    endproperty
    property p_dev_start;
        s_dev_granted |=> dev_oe;
    endproperty
    property p_dev_ack_first;
        $rose(dev_oe) |-> $past(peer_ack) && $past(dev_req);
    endproperty
    property p_dev_hold;
        dev_oe |-> dev_req && peer_ack;
    endproperty
    property p_dev_len;
        $fell(dev_oe) |-> $past(dev_cnt_q) == OE_LEN - 1;
    endproperty
    property p_dev_bytes;
        dev_oe && (dev_cnt_q % BYTE_CYC) != 0 |-> $stable(dat);
    endproperty
    property p_dev_end;
        $fell(dev_oe) |-> !dev_req && !peer_ack;
    endproperty
    property p_peer_start;
        s_peer_granted |=> peer_oe;
    endproperty
    property p_peer_hold;
        peer_oe |-> peer_req && dev_ack;
    endproperty
    property p_peer_len;
        peer_oe && peer_cnt_q == OE_LEN - 1 |=> !peer_oe;
    endproperty

    a_one_driver: assert property (p_one_driver)
        else $error("both ends drive the data lines");
    a_dev_start: assert property (p_dev_start)
        else $error("device bytes did not follow the grant");
    a_dev_ack_first: assert property (p_dev_ack_first)
        else $error("device drove data without a grant");
    a_dev_hold: assert property (p_dev_hold)
        else $error("handshake dropped during device word");
    a_dev_len: assert property (p_dev_len)
        else $error("device drive time wrong");
    a_dev_bytes: assert property (p_dev_bytes)
        else $error("byte changed inside its slot");
    a_dev_end: assert property (p_dev_end)
        else $error("handshake outlived the device word");
    a_peer_start: assert property (p_peer_start)
        else $error("far end bytes did not follow the grant");
    a_peer_hold: assert property (p_peer_hold)
        else $error("handshake dropped during far end word");
    a_peer_len: assert property (p_peer_len)
        else $error("far end drove too long");
endmodule

`default_nettype wire

// [testbench/test_byte_wide_interprocessor_port.sv]
// testbench joining both ends of the port across one link
`timescale 1ns/100ps
`default_nettype none

module test_byte_wide_interprocessor_port;
    // short byte slots keep the run brief; pacing is the same logic
    localparam int BC = 2;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic tx_wr = 1'b0;
    logic [31:0] tx_wdata = 32'h0;
    logic rx_rd = 1'b0;
    logic p_tx_valid = 1'b0;
    logic [31:0] p_tx_data = 32'h0;
    logic tx_full;
    logic tx_empty;
    logic [31:0] rx_rdata;
    logic rx_full;
    logic rx_empty;
    logic p_tx_ready;
    logic p_rx_valid;
    logic [31:0] p_rx_data;
    int failures = 0;
    int n_compared = 0;

    always #2.5 clk_i = ~clk_i;

    bwip_link_if link ();
    bwip_dev_port #(.DEPTH(8), .BYTE_CYC(BC), .HIGH_PRIO(1'b1)) bwip_dev_port_inst (.clk_i(clk_i),
        .rst_n_i(rst_n_i), .tx_wr_i(tx_wr), .tx_wdata_i(tx_wdata), .tx_full_o(tx_full), .tx_empty_o(tx_empty),
        .rx_rd_i(rx_rd), .rx_rdata_o(rx_rdata), .rx_full_o(rx_full), .rx_empty_o(rx_empty), .link(link));
    bwip_peer_port #(.BYTE_CYC(BC), .HIGH_PRIO(1'b0)) bwip_peer_port_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .tx_valid_i(p_tx_valid), .tx_data_i(p_tx_data), .tx_ready_o(p_tx_ready), .rx_valid_o(p_rx_valid),
        .rx_data_o(p_rx_data), .link(link));
    bwip_link_checker #(.BYTE_CYC(BC)) bwip_link_checker_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .dev_req(link.dev_req), .dev_ack(link.dev_ack), .peer_req(link.peer_req), .peer_ack(link.peer_ack),
        .dev_oe(link.dev_oe), .peer_oe(link.peer_oe), .dat(link.dat));

    task automatic print_verdict();
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    task automatic give_up();
        failures++;
        $display("unexpected at %0t: wait ran out", $time);
        print_verdict();
    endtask

    task automatic pop();
        @(posedge clk_i);
        rx_rd <= 1'b1;
        @(posedge clk_i);
        rx_rd <= 1'b0;
        #1;
    endtask

    // follows one word on the wire; returns in the cycle after its last slot
    task automatic wire_bytes(input logic [31:0] w, input bit from_dev);
        int i;
        int k;
        // look at settled values, never at the edge that launches them
        #1;
        for (i = 0; i < 200 && (from_dev ? link.dev_oe : link.peer_oe) !== 1'b1; i++) begin
            @(posedge clk_i);
            #1;
        end
        if (i == 200) give_up();
        for (k = 0; k < 4; k++) begin
            check(32'(link.dat), 32'(w[8*k+:8]));
            repeat (BC) @(posedge clk_i);
            #1;
        end
        check(32'(from_dev ? link.dev_oe : link.peer_oe), 32'h0);
    endtask

    task automatic peer_send(input logic [31:0] w, input bit watch);
        int i;
        @(posedge clk_i);
        p_tx_valid <= 1'b1;
        p_tx_data <= w;
        #1;
        for (i = 0; i < 400 && p_tx_ready !== 1'b1; i++) begin
            @(posedge clk_i);
            #1;
        end
        if (i == 400) give_up();
        @(posedge clk_i);
        p_tx_valid <= 1'b0;
        if (watch) wire_bytes(w, 1'b0);
    endtask

    task automatic wait_rx();
        int i;
        for (i = 0; i < 200 && rx_empty !== 1'b0; i++) begin
            @(posedge clk_i);
            #1;
        end
        if (i == 200) give_up();
    endtask

    task automatic t_reset();
        @(posedge clk_i);
        #1;
        check(32'({tx_empty, rx_empty, tx_full, rx_full, p_tx_ready, p_rx_valid}), 32'h32);
        repeat (10) @(posedge clk_i);
        #1;
        check(32'({link.dev_req, link.peer_req, link.dev_oe, link.peer_oe}), 32'h0);
        $display("done: reset");
    endtask

    // three words queued back to back leave in order
    task automatic t_dev();
        logic [31:0] w [3];
        w = '{32'h8142_c3e5, 32'h0000_0001, 32'hffff_ff00};
        // writes on consecutive edges, so the first word is not yet on the wire
        @(posedge clk_i);
        for (int k = 0; k < 3; k++) begin
            tx_wr <= 1'b1;
            tx_wdata <= w[k];
            @(posedge clk_i);
        end
        tx_wr <= 1'b0;
        for (int k = 0; k < 3; k++) begin
            wire_bytes(w[k], 1'b1);
            check(32'(p_rx_valid), 32'h1);
            check(p_rx_data, w[k]);
        end
        check(32'(tx_empty), 32'h1);
        $display("done: device to far end");
    endtask

    // receive side fills, ack is withheld, then drains in order
    task automatic t_fill();
        for (int k = 0; k < 8; k++) begin
            peer_send(32'h5a00_0000 + 32'(k), 1'b1);
            check(32'(rx_full), 32'(k == 7));
        end
        peer_send(32'h5a00_0008, 1'b0);
        repeat (12) begin
            @(posedge clk_i);
            #1;
            check(32'({link.peer_req, link.dev_ack, link.peer_oe}), 32'h4);
        end
        for (int k = 0; k < 9; k++) begin
            wait_rx();
            check(rx_rdata, 32'h5a00_0000 + 32'(k));
            pop();
        end
        check(32'(rx_empty), 32'h1);
        $display("done: receive full");
    endtask

    // both ends want the link at once: device first, then far end
    task automatic t_both();
        @(posedge clk_i);
        tx_wr <= 1'b1;
        tx_wdata <= 32'h0f1e_2d3c;
        p_tx_valid <= 1'b1;
        p_tx_data <= 32'hb4a5_9687;
        @(posedge clk_i);
        tx_wr <= 1'b0;
        p_tx_valid <= 1'b0;
        wire_bytes(32'h0f1e_2d3c, 1'b1);
        check(p_rx_data, 32'h0f1e_2d3c);
        check(32'(rx_empty), 32'h1);
        wire_bytes(32'hb4a5_9687, 1'b0);
        check(32'(rx_empty), 32'h0);
        check(rx_rdata, 32'hb4a5_9687);
        pop();
        $display("done: both directions");
    endtask

    initial begin
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_reset();
        t_dev();
        t_fill();
        t_both();
        print_verdict();
    end
endmodule

`default_nettype wire
